/* design/gtp_gpio_ctrl.sv */
// Operation
// - Port A sixteen pending flags, write one clears, zero leaves alone.
// - Port B sixteen pending flags, same write-one-to-clear behaviour.
// - Port B flags 9:8 follow pins 23:22 or 9:8 per remap select.
// - Port A direction bit one makes output, zero makes input.
// - Port A input register reads live pin levels.
// - Port A output pin drives its output bit while direction is one.
// - Input pin's output bit chooses interrupt polarity high/rising or low/falling.
// - Writing one to port A clear bit zeroes that output bit.
// - Port A pull-up bit enables the pin pull-up.
// - Input pin's pull-down/drive bit enables pull-down.
// - Output pin's pull-down/drive bit selects strong versus weak drive.
// - Twenty-four port B direction bits, one output, zero input.
// - Port B input register reads all twenty-four pin levels.
// - Port B output pin drives its output bit while direction is one.
// - Per-pin interrupt enables for both ports, reset to zero.
// - Per-pin mode bit: one edge trigger, zero level trigger.
`timescale 1ns/1ps
module gtp_gpio_ctrl #(
    parameter int unsigned PA_WIDTH = gtp_pkg::GTP_PA_PINS,
    parameter int unsigned PB_WIDTH = gtp_pkg::GTP_PB_PINS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [gtp_pkg::GTP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [gtp_pkg::GTP_DATA_W-1:0] s_axi_wdata,
    input wire logic [gtp_pkg::GTP_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gtp_pkg::GTP_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [gtp_pkg::GTP_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PA_WIDTH-1:0] pa_pin_in,
    output logic [PA_WIDTH-1:0] pa_pin_out,
    output logic [PA_WIDTH-1:0] pa_pin_oe,
    output logic [PA_WIDTH-1:0] pa_pullup_en,
    output logic [PA_WIDTH-1:0] pa_pulldown_en,
    output logic [PA_WIDTH-1:0] pa_drive_strong,
    input wire logic [PB_WIDTH-1:0] pb_pin_in,
    output logic [PB_WIDTH-1:0] pb_pin_out,
    output logic [PB_WIDTH-1:0] pb_pin_oe
);

    localparam int unsigned DW = gtp_pkg::GTP_DATA_W;
    localparam int unsigned IB = gtp_pkg::GTP_IRQ_BITS;
    localparam int unsigned RF = gtp_pkg::GTP_REMAP_FLAG_LO;
    localparam int unsigned RP = gtp_pkg::GTP_REMAP_PIN_LO;

    // Remap needs pins 23:22, and every register is one bus word
    if (PA_WIDTH < IB || PA_WIDTH > DW) begin : g_pa_check
        $error("gtp_gpio_ctrl: PA_WIDTH out of range");
    end
    if (PB_WIDTH < RP + 2 || PB_WIDTH > DW) begin : g_pb_check
        $error("gtp_gpio_ctrl: PB_WIDTH out of range");
    end

    // Byte strobes to a bit mask
    function automatic logic [DW-1:0] strb_mask(input logic [gtp_pkg::GTP_STRB_W-1:0] strb);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < gtp_pkg::GTP_STRB_W; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] data,
                                            input logic [DW-1:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction

    // Word-aligned address compare
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
        return (addr & gtp_pkg::GTP_WORD_MASK) == off;
    endfunction

    // Bus write channel holding
    logic aw_full;
    logic w_full;
    logic [7:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [DW-1:0] wr_mask;
    logic wr_fire;
    logic wr_known;

    // Register state
    logic [PA_WIDTH-1:0] pa_dir;
    logic [PA_WIDTH-1:0] pa_out;
    logic [PA_WIDTH-1:0] pa_pu;
    logic [PA_WIDTH-1:0] pa_pd_drv;
    logic [IB-1:0] pa_ien;
    logic [IB-1:0] pa_mode;
    logic [IB-1:0] pa_flags;
    logic [PB_WIDTH-1:0] pb_dir;
    logic [PB_WIDTH-1:0] pb_out;
    logic [IB-1:0] pb_ien;
    logic [IB-1:0] pb_mode;
    logic [IB-1:0] pb_flags;
    logic remap;

    // Interrupt source views
    logic [IB-1:0] pa_hit;
    logic [IB-1:0] pb_hit;
    logic [IB-1:0] pb_irq_level;
    logic [IB-1:0] pb_irq_pol;
    logic [IB-1:0] pb_irq_input;

    // Read path
    logic [DW-1:0] next_rdata;
    logic next_rok;

    // Masked write data, still full bus width; cut to register widths where used
    logic [DW-1:0] wr_bits;
    logic [DW-1:0] wr_sel;

    assign wr_fire = aw_full & w_full & ~s_axi_bvalid;
    assign wr_bits = wr_data & wr_mask;
    assign wr_sel = wr_mask;

    // Write address and data taken in either order
    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full & ~s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            aw_full <= 1'b0;
            wr_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            w_full <= 1'b0;
            wr_data <= '0;
            wr_mask <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_mask <= strb_mask(s_axi_wstrb);
        end else if (wr_fire) begin
            w_full <= 1'b0;
        end
    end

    // Unmapped writes are dropped and answered with an error
    always_comb begin
        case (wr_addr & gtp_pkg::GTP_WORD_MASK)
            gtp_pkg::GTP_OFF_PA_IRQ_FLAGS, gtp_pkg::GTP_OFF_PB_IRQ_FLAGS,
            gtp_pkg::GTP_OFF_PA_IRQ_ENABLE, gtp_pkg::GTP_OFF_PB_IRQ_ENABLE,
            gtp_pkg::GTP_OFF_PA_IRQ_MODE, gtp_pkg::GTP_OFF_PB_IRQ_MODE,
            gtp_pkg::GTP_OFF_IRQ_REMAP, gtp_pkg::GTP_OFF_PA_DIRECTION,
            gtp_pkg::GTP_OFF_PA_INPUT, gtp_pkg::GTP_OFF_PA_OUTPUT,
            gtp_pkg::GTP_OFF_PA_CLEAR, gtp_pkg::GTP_OFF_PA_PULLUP,
            gtp_pkg::GTP_OFF_PA_PD_DRV, gtp_pkg::GTP_OFF_PB_DIRECTION,
            gtp_pkg::GTP_OFF_PB_INPUT, gtp_pkg::GTP_OFF_PB_OUTPUT: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gtp_pkg::GTP_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? gtp_pkg::GTP_RESP_OKAY : gtp_pkg::GTP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Port A configuration
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_dir <= PA_WIDTH'(gtp_pkg::GTP_RST_WORD);
            pa_pu <= PA_WIDTH'(gtp_pkg::GTP_RST_WORD);
            pa_pd_drv <= PA_WIDTH'(gtp_pkg::GTP_RST_WORD);
        end else if (wr_fire) begin
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_DIRECTION)) begin
                pa_dir <= PA_WIDTH'(merge(DW'(pa_dir), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_PULLUP)) begin
                pa_pu <= PA_WIDTH'(merge(DW'(pa_pu), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_PD_DRV)) begin
                pa_pd_drv <= PA_WIDTH'(merge(DW'(pa_pd_drv), wr_data, wr_mask));
            end
        end
    end

    // Port A output level, with its clear register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_out <= PA_WIDTH'(gtp_pkg::GTP_RST_WORD);
        end else if (wr_fire && addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_OUTPUT)) begin
            pa_out <= PA_WIDTH'(merge(DW'(pa_out), wr_data, wr_mask));
        end else if (wr_fire && addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_CLEAR)) begin
            pa_out <= pa_out & ~PA_WIDTH'(wr_bits);
        end
    end

    // Port B configuration and output level
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pb_dir <= PB_WIDTH'(gtp_pkg::GTP_RST_WORD);
            pb_out <= PB_WIDTH'(gtp_pkg::GTP_RST_WORD);
        end else if (wr_fire) begin
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PB_DIRECTION)) begin
                pb_dir <= PB_WIDTH'(merge(DW'(pb_dir), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PB_OUTPUT)) begin
                pb_out <= PB_WIDTH'(merge(DW'(pb_out), wr_data, wr_mask));
            end
        end
    end

    // Interrupt enables, modes and remap select
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_ien <= IB'(gtp_pkg::GTP_RST_WORD);
            pb_ien <= IB'(gtp_pkg::GTP_RST_WORD);
            pa_mode <= IB'(gtp_pkg::GTP_RST_WORD);
            pb_mode <= IB'(gtp_pkg::GTP_RST_WORD);
            remap <= gtp_pkg::GTP_RST_BIT;
        end else if (wr_fire) begin
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_IRQ_ENABLE)) begin
                pa_ien <= IB'(merge(DW'(pa_ien), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PB_IRQ_ENABLE)) begin
                pb_ien <= IB'(merge(DW'(pb_ien), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_IRQ_MODE)) begin
                pa_mode <= IB'(merge(DW'(pa_mode), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_PB_IRQ_MODE)) begin
                pb_mode <= IB'(merge(DW'(pb_mode), wr_data, wr_mask));
            end
            if (addr_is(wr_addr, gtp_pkg::GTP_OFF_IRQ_REMAP) &&
                wr_sel[gtp_pkg::GTP_REMAP_BIT]) begin
                remap <= wr_data[gtp_pkg::GTP_REMAP_BIT];
            end
        end
    end

    // Port B interrupt view, flags 9:8 shared between two pin pairs
    always_comb begin
        pb_irq_level = pb_pin_in[IB-1:0];
        pb_irq_pol = pb_out[IB-1:0];
        pb_irq_input = ~pb_dir[IB-1:0];
        if (remap) begin
            pb_irq_level[RF +: 2] = pb_pin_in[RP +: 2];
            pb_irq_pol[RF +: 2] = pb_out[RP +: 2];
            pb_irq_input[RF +: 2] = ~pb_dir[RP +: 2];
        end
    end

    // Switching remap may look like an edge on flags 9:8; mask first
    gtp_irq_detect #(
        .WIDTH(IB)
    ) u_pa_detect (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .level(pa_pin_in[IB-1:0]),
        .polarity(pa_out[IB-1:0]),
        .enable(pa_ien),
        .edge_mode(pa_mode),
        .is_input(~pa_dir[IB-1:0]),
        .hit(pa_hit)
    );

    gtp_irq_detect #(
        .WIDTH(IB)
    ) u_pb_detect (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .level(pb_irq_level),
        .polarity(pb_irq_pol),
        .enable(pb_ien),
        .edge_mode(pb_mode),
        .is_input(pb_irq_input),
        .hit(pb_hit)
    );

    // Flags: a new hit beats a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_flags <= IB'(gtp_pkg::GTP_RST_WORD);
            pb_flags <= IB'(gtp_pkg::GTP_RST_WORD);
        end else begin
            if (wr_fire && addr_is(wr_addr, gtp_pkg::GTP_OFF_PA_IRQ_FLAGS)) begin
                pa_flags <= (pa_flags & ~IB'(wr_bits)) | pa_hit;
            end else begin
                pa_flags <= pa_flags | pa_hit;
            end
            if (wr_fire && addr_is(wr_addr, gtp_pkg::GTP_OFF_PB_IRQ_FLAGS)) begin
                pb_flags <= (pb_flags & ~IB'(wr_bits)) | pb_hit;
            end else begin
                pb_flags <= pb_flags | pb_hit;
            end
        end
    end

    // Read decode; unused upper bits read zero
    always_comb begin
        next_rdata = '0;
        next_rok = 1'b1;
        case (s_axi_araddr & gtp_pkg::GTP_WORD_MASK)
            gtp_pkg::GTP_OFF_PA_IRQ_FLAGS: next_rdata = DW'(pa_flags);
            gtp_pkg::GTP_OFF_PB_IRQ_FLAGS: next_rdata = DW'(pb_flags);
            gtp_pkg::GTP_OFF_PA_IRQ_ENABLE: next_rdata = DW'(pa_ien);
            gtp_pkg::GTP_OFF_PB_IRQ_ENABLE: next_rdata = DW'(pb_ien);
            gtp_pkg::GTP_OFF_PA_IRQ_MODE: next_rdata = DW'(pa_mode);
            gtp_pkg::GTP_OFF_PB_IRQ_MODE: next_rdata = DW'(pb_mode);
            gtp_pkg::GTP_OFF_IRQ_REMAP: next_rdata = DW'(remap);
            gtp_pkg::GTP_OFF_PA_DIRECTION: next_rdata = DW'(pa_dir);
            gtp_pkg::GTP_OFF_PA_INPUT: next_rdata = DW'(pa_pin_in);
            gtp_pkg::GTP_OFF_PA_OUTPUT: next_rdata = DW'(pa_out);
            gtp_pkg::GTP_OFF_PA_CLEAR: next_rdata = '0;
            gtp_pkg::GTP_OFF_PA_PULLUP: next_rdata = DW'(pa_pu);
            gtp_pkg::GTP_OFF_PA_PD_DRV: next_rdata = DW'(pa_pd_drv);
            gtp_pkg::GTP_OFF_PB_DIRECTION: next_rdata = DW'(pb_dir);
            gtp_pkg::GTP_OFF_PB_INPUT: next_rdata = DW'(pb_pin_in);
            gtp_pkg::GTP_OFF_PB_OUTPUT: next_rdata = DW'(pb_out);
            default: next_rok = 1'b0;
        endcase
    end

    // One read in flight; a new address only after the data is taken
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= gtp_pkg::GTP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rok ? gtp_pkg::GTP_RESP_OKAY : gtp_pkg::GTP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pin controls from register flops; pull-down and drive strength gated by direction
    assign pa_pin_out = pa_out;
    assign pa_pin_oe = pa_dir;
    assign pa_pullup_en = pa_pu;
    assign pa_pulldown_en = pa_pd_drv & ~pa_dir;
    assign pa_drive_strong = pa_pd_drv & pa_dir;
    assign pb_pin_out = pb_out;
    assign pb_pin_oe = pb_dir;

endmodule // gtp_gpio_ctrl

/* design/gtp_pkg.sv */
package gtp_pkg;

    // Pin counts per port
    localparam int unsigned GTP_PA_PINS = 16;
    localparam int unsigned GTP_PB_PINS = 24;
    localparam int unsigned GTP_IRQ_BITS = 16;

    // Register bus geometry
    localparam int unsigned GTP_ADDR_W = 8;
    localparam int unsigned GTP_DATA_W = 32;
    localparam int unsigned GTP_STRB_W = 4;

    // Register byte offsets
    localparam logic [7:0] GTP_OFF_PA_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] GTP_OFF_PB_IRQ_FLAGS = 8'h04;
    localparam logic [7:0] GTP_OFF_PA_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] GTP_OFF_PB_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] GTP_OFF_PA_IRQ_MODE = 8'h10;
    localparam logic [7:0] GTP_OFF_PB_IRQ_MODE = 8'h14;
    localparam logic [7:0] GTP_OFF_IRQ_REMAP = 8'h18;
    localparam logic [7:0] GTP_OFF_PA_DIRECTION = 8'h20;
    localparam logic [7:0] GTP_OFF_PA_INPUT = 8'h24;
    localparam logic [7:0] GTP_OFF_PA_OUTPUT = 8'h28;
    localparam logic [7:0] GTP_OFF_PA_CLEAR = 8'h2c;
    localparam logic [7:0] GTP_OFF_PA_PULLUP = 8'h30;
    localparam logic [7:0] GTP_OFF_PA_PD_DRV = 8'h34;
    localparam logic [7:0] GTP_OFF_PB_DIRECTION = 8'h40;
    localparam logic [7:0] GTP_OFF_PB_INPUT = 8'h44;
    localparam logic [7:0] GTP_OFF_PB_OUTPUT = 8'h48;

    // Word alignment mask for decode
    localparam logic [7:0] GTP_WORD_MASK = 8'hfc;

    // Reset values
    localparam logic [31:0] GTP_RST_WORD = 32'h0000_0000;
    localparam logic GTP_RST_BIT = 1'b0;

    // Remap select bit and the shared flag positions
    localparam int unsigned GTP_REMAP_BIT = 0;
    localparam int unsigned GTP_REMAP_FLAG_LO = 8;
    localparam int unsigned GTP_REMAP_PIN_LO = 22;

    // Bus responses
    localparam logic [1:0] GTP_RESP_OKAY = 2'h0;
    localparam logic [1:0] GTP_RESP_SLVERR = 2'h2;

endpackage

/* design/gtp_irq_detect.sv */
`timescale 1ns/1ps
module gtp_irq_detect #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] polarity,
    input wire logic [WIDTH-1:0] enable,
    input wire logic [WIDTH-1:0] edge_mode,
    input wire logic [WIDTH-1:0] is_input,
    output logic [WIDTH-1:0] hit
);

    logic [WIDTH-1:0] prev_level;
    logic [WIDTH-1:0] matched;
    logic [WIDTH-1:0] changed;

    // Previous level, not previous match, so a polarity change alone never fires an edge-mode pin
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prev_level <= '0;
        end else begin
            prev_level <= level;
        end
    end

    assign matched = ~(level ^ polarity);
    assign changed = level ^ prev_level;

    // Edge when changed into the chosen polarity, else level while matching
    assign hit = enable & is_input & matched & (~edge_mode | changed);

endmodule // gtp_irq_detect

/* dv/gtp_gpio_ctrl_chk.sv */
`timescale 1ns/1ps
module gtp_gpio_ctrl_chk #(
    parameter int unsigned PA_WIDTH = 16,
    parameter int unsigned PB_WIDTH = 24
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PA_WIDTH-1:0] pa_pin_in,
    input wire logic [PA_WIDTH-1:0] pa_pin_out,
    input wire logic [PA_WIDTH-1:0] pa_pin_oe,
    input wire logic [PA_WIDTH-1:0] pa_pullup_en,
    input wire logic [PA_WIDTH-1:0] pa_pulldown_en,
    input wire logic [PA_WIDTH-1:0] pa_drive_strong,
    input wire logic [PB_WIDTH-1:0] pb_pin_in,
    input wire logic [PB_WIDTH-1:0] pb_pin_out,
    input wire logic [PB_WIDTH-1:0] pb_pin_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
        && s_axi_awready && s_axi_wready) else $error("write channel not freed");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    ar_refuse_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    pd_split_a: assert property ((pa_pulldown_en & pa_pin_oe) == '0)
        else $error("pull-down on output pin");
    drv_split_a: assert property ((pa_drive_strong & ~pa_pin_oe) == '0)
        else $error("drive strength on input pin");
    // Pin controls may move only with a completed write
    cfg_quiet_a: assert property (!$rose(s_axi_bvalid) |-> $stable(pa_pin_oe)
        && $stable(pa_pin_out) && $stable(pa_pullup_en) && $stable(pb_pin_out)
        && $stable(pb_pin_oe)) else $error("pin control changed without write");
    rst_clear_a: assert property ($rose(reset_n) |-> pa_pin_oe == '0 && pb_pin_oe == '0
        && pa_pin_out == '0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset state wrong");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($rose(s_axi_rvalid));
    cover property ($changed(pa_pin_oe));
endmodule // gtp_gpio_ctrl_chk
bind gtp_gpio_ctrl gtp_gpio_ctrl_chk #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH)) i_chk (.*);

/* dv/gtp_pin_model.sv */
`timescale 1ns/1ps
module gtp_pin_model (
    input wire logic core_clk,
    input wire logic [15:0] pa_pin_out,
    input wire logic [15:0] pa_pin_oe,
    input wire logic [15:0] pa_pullup_en,
    input wire logic [15:0] pa_pulldown_en,
    input wire logic [15:0] ext_a,
    input wire logic [15:0] ext_a_en,
    output logic [15:0] pa_pin_in,
    input wire logic [23:0] pb_pin_out,
    input wire logic [23:0] pb_pin_oe,
    input wire logic [23:0] ext_b,
    output logic [23:0] pb_pin_in
);
    logic [15:0] wander = '0;
    // Undriven unpulled pin never holds a tidy value
    always_ff @(posedge core_clk) wander <= ~wander;
    assign pa_pin_in = (pa_pin_oe & pa_pin_out)
        | (~pa_pin_oe & ((ext_a_en & ext_a)
        | (~ext_a_en & (pa_pullup_en | (~pa_pulldown_en & wander)))));
    assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & ext_b);
endmodule // gtp_pin_model

/* dv/gpio_two_port_pin_control_tb_top.sv */
`timescale 1ns/1ps
module gpio_two_port_pin_control_tb_top;
    logic core_clk, reset_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] pa_pin_in, pa_pin_out, pa_pin_oe, pa_pullup_en, pa_pulldown_en, pa_drive_strong;
    logic [15:0] ext_a, ext_a_en;
    logic [23:0] pb_pin_in, pb_pin_out, pb_pin_oe, ext_b;
    int failures, total_checks;
    logic [7:0] offs [16] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20,
        8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h40, 8'h44, 8'h48};

    gtp_gpio_ctrl i_dut (.*);
    gtp_pin_model i_pins (.core_clk(core_clk), .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
        .pa_pullup_en(pa_pullup_en), .pa_pulldown_en(pa_pulldown_en), .ext_a(ext_a),
        .ext_a_en(ext_a_en), .pa_pin_in(pa_pin_in), .pb_pin_out(pb_pin_out),
        .pb_pin_oe(pb_pin_oe), .ext_b(ext_b), .pb_pin_in(pb_pin_in));

    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        chk("bvalid", 32'h1, 32'(s_axi_bvalid));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        chk("rvalid", 32'h1, 32'(s_axi_rvalid));
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        rd(a);
        chk(nm, exp, rdat);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        wrap_up();
    end
    initial begin
        reset_n <= 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} <= '0;
        {s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
        {s_axi_arvalid, s_axi_rready} <= '0;
        ext_a <= '0;
        ext_a_en <= 16'hffff;
        ext_b <= '0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (offs[i]) rdc(offs[i], 32'h0, "reset value");
        wr(8'h20, 32'hffff_00ff);
        wr(8'h28, 32'h0000_a5a5);
        ext_a <= 16'h3c00;
        rdc(8'h20, 32'h0000_00ff, "pa_dir");
        chk("pa_oe", 32'h00ff, 32'(pa_pin_oe));
        rdc(8'h24, 32'h0000_3ca5, "pa_in");
        wr(8'h2c, 32'h0000_0f0f);
        rdc(8'h28, 32'h0000_a0a0, "pa_out_clr");
        rdc(8'h2c, 32'h0, "pa_clr_read");
        wr(8'h30, 32'h0000_1234);
        wr(8'h34, 32'h0000_0f0f);
        chk("pa_pu", 32'h1234, 32'(pa_pullup_en));
        chk("pa_pd", 32'h0f00, 32'(pa_pulldown_en));
        chk("pa_drv", 32'h000f, 32'(pa_drive_strong));
        wr(8'h30, 32'hffff_ffff, 4'h2);
        rdc(8'h30, 32'h0000_ff34, "pa_pu_strobe");
        wr(8'h40, 32'h00ff_0000);
        wr(8'h48, 32'hffab_cdef);
        ext_b <= 24'h123456;
        rdc(8'h48, 32'h00ab_cdef, "pb_out");
        chk("pb_oe", 32'h00ff_0000, 32'(pb_pin_oe));
        rdc(8'h44, 32'h00ab_3456, "pb_in");
        // Pins 8 and 9 high polarity, 12 low polarity edge, 0 is an output
        ext_a <= 16'h0000;
        wr(8'h28, 32'h0000_0f00);
        wr(8'h10, 32'h0000_1200);
        wr(8'h08, 32'h0000_1301);
        rdc(8'h00, 32'h0, "pa_flag_idle");
        ext_a <= 16'h0100;
        repeat (3) @(posedge core_clk);
        rdc(8'h00, 32'h0000_0100, "pa_flag_level");
        wr(8'h00, 32'h0000_0100);
        rdc(8'h00, 32'h0000_0100, "pa_flag_relevel");
        ext_a <= 16'h0000;
        wr(8'h00, 32'h0000_0100);
        rdc(8'h00, 32'h0, "pa_flag_w1c");
        ext_a <= 16'h1200;
        repeat (3) @(posedge core_clk);
        rdc(8'h00, 32'h0000_0200, "pa_flag_rise");
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h0000_0200, "pa_flag_w0");
        wr(8'h00, 32'h0000_0200);
        rdc(8'h00, 32'h0, "pa_flag_once");
        ext_a <= 16'h0200;
        repeat (3) @(posedge core_clk);
        rdc(8'h00, 32'h0000_1000, "pa_flag_fall");
        ext_b <= 24'hffffff;
        wr(8'h40, 32'h0);
        wr(8'h48, 32'h0);
        wr(8'h0c, 32'h0000_0300);
        rdc(8'h04, 32'h0, "pb_flag_idle");
        ext_b <= 24'hfffdff;
        repeat (3) @(posedge core_clk);
        rdc(8'h04, 32'h0000_0200, "pb_flag_pin9");
        ext_b <= 24'hbfffff;
        wr(8'h04, 32'h0000_0200);
        rdc(8'h04, 32'h0, "pb_flag_clr");
        wr(8'h18, 32'h1);
        rdc(8'h04, 32'h0000_0100, "pb_flag_remap");
        wr(8'h50, 32'hffff_ffff);
        chk("bresp_unmapped", 32'(gtp_pkg::GTP_RESP_SLVERR), 32'(resp));
        rdc(8'h50, 32'h0, "rdata_unmapped");
        chk("rresp_unmapped", 32'(gtp_pkg::GTP_RESP_SLVERR), 32'(resp));
        wr(8'h24, 32'hffff_ffff);
        chk("bresp_ro", 32'(gtp_pkg::GTP_RESP_OKAY), 32'(resp));
        rdc(8'h24, 32'h0000_0200, "pa_in_ro");
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        chk("pa_oe_reset", 32'h0, 32'(pa_pin_oe));
        rdc(8'h40, 32'h0, "pb_dir_reset");
        wrap_up();
    end
endmodule // gpio_two_port_pin_control_tb_top
